// >>> lcddc_pkg.sv
// package of the dot matrix lcd driver control block
// assumes a 100 MHz hclk and byte registers placed one per aligned bus word
package lcddc_pkg;

  // ************************************************************
  // register and display memory placement (word indexes)
  // ************************************************************
  localparam logic [15:0] REG_MODE_IDX = 16'hFF10;
  localparam logic [15:0] REG_DISP_IDX = 16'hFF11;
  localparam logic [7:0] DMEM_PAGE_FIRST = 8'hF8;
  localparam logic [7:0] DMEM_PAGE_LAST = 8'hFD;
  localparam logic [7:0] DMEM_OFF_LAST = 8'h4F;
  localparam int DMEM_BYTES = 480;
  localparam int DMEM_AW = 9;
  localparam int SEG_COUNT = 80;
  localparam int COM_COUNT = 16;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MODE_HLP_BIT = 7;
  localparam int MODE_RSVA_BIT = 4;
  localparam int MODE_RSVB_BIT = 3;
  localparam int MODE_FONT_BIT = 2;
  localparam int MODE_DUTY_BIT = 1;
  localparam int MODE_RSVC_BIT = 0;
  localparam int DISP_AREA_BIT = 6;
  localparam int DISP_STATE_LSB = 4;
  localparam int DISP_CON_LSB = 0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic RST_DUTY = 1'b1;
  localparam logic RST_FONT = 1'b0;
  localparam logic RST_AREA = 1'b0;
  localparam logic [1:0] RST_STATE = 2'h0;
  localparam logic [3:0] RST_CONTRAST = 4'h0;
  localparam logic RST_RSV = 1'b0;

  // ************************************************************
  // display states and common timing
  // ************************************************************
  typedef enum logic [1:0] {
    DS_DRIVE_OFF = 2'h0,
    DS_NORMAL = 2'h1,
    DS_ALL_OFF = 2'h2,
    DS_ALL_ON = 2'h3
  } lcddc_state_type;

  localparam int COM_TIME_US = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int COM_CYCLES = (COM_TIME_US * 1000) / CLK_PERIOD_NS;

  typedef struct packed {
    logic duty_select;
    logic font_select;
    logic area_select;
    lcddc_state_type display_state;
    logic [3:0] contrast_code;
  } lcddc_cfg_type;

endpackage

// >>> lcddc_mem.sv
// display memory: one read/write port for software, one read port for scanning
// assumes both ports on one clock; read data come from registers
`timescale 1ns/10ps
module lcddc_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 480,
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] a_addr,
  input wire logic a_we,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  input wire logic [AW-1:0] b_addr,
  output logic [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [DEPTH];

  // no reset on the array: contents after power-up are undefined, as in a ram
  always_ff @(posedge clk) begin
    if (a_we) begin
      mem[a_addr] <= a_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_rdata <= '0;
      b_rdata <= '0;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end

endmodule

// >>> lcddc_top.sv
// dot matrix lcd driver control: ahb-lite registers, display memory, common scan
// assumes hclk at 100 MHz, single word transfers, sleep pulse on hclk
`timescale 1ns/10ps
module lcddc_top
  import lcddc_pkg::*;
#(
  parameter int COM_TICK = COM_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic sleep_instruction,
  output logic dmem_select,
  output logic [COM_COUNT-1:0] common_outputs,
  output logic [SEG_COUNT-1:0] segment_outputs,
  output logic [3:0] drive_level_on,
  output logic [3:0] contrast_code,
  output logic heavy_load_protect
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [DMEM_AW-1:0] dmem_index(input logic [2:0] pg,
                                                    input logic [6:0] off);
    logic [DMEM_AW-1:0] base;
    base = DMEM_AW'({pg, 6'h00}) + DMEM_AW'({pg, 4'h0});
    return base + DMEM_AW'(off);
  endfunction

  // page and bit of common c inside the chosen area and layout
  function automatic logic [5:0] scan_loc(input lcddc_cfg_type c, input logic [3:0] com);
    logic [2:0] pg;
    logic [2:0] bt;
    pg = c.area_select ? 3'h2 : 3'h0;
    if (c.font_select) begin
      pg = pg + 3'(com / 4'h5);
      bt = 3'(com % 4'h5);
    end else begin
      pg = pg + {2'h0, com[3]};
      bt = com[2:0];
    end
    return {pg, bt};
  endfunction

  // ************************************************************
  // ahb-lite slave
  // ************************************************************
  logic ap_valid;
  logic [15:0] ap_idx;
  logic ph_valid_r;
  logic ph_write_r;
  logic [15:0] ph_idx_r;
  logic ph_wait_r;
  logic ph_is_mem;
  logic ph_is_mode;
  logic ph_is_disp;
  logic [DMEM_AW-1:0] ph_mem_idx;
  logic mem_we;
  logic [7:0] mem_rdata;

  assign ap_valid = hsel && htrans[1] && hready;
  assign ap_idx = haddr[17:2];
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_idx_r <= '0;
    end else if (hreadyout) begin
      ph_valid_r <= ap_valid && (haddr[31:18] == 14'h0000);
      ph_write_r <= hwrite;
      ph_idx_r <= ap_idx;
    end
  end

  assign ph_is_mem = (ph_idx_r[15:8] >= DMEM_PAGE_FIRST) && (ph_idx_r[15:8] <= DMEM_PAGE_LAST)
                     && (ph_idx_r[7:0] <= DMEM_OFF_LAST);
  assign ph_is_mode = ph_idx_r == REG_MODE_IDX;
  assign ph_is_disp = ph_idx_r == REG_DISP_IDX;
  assign ph_mem_idx = dmem_index(3'(ph_idx_r[15:8] - DMEM_PAGE_FIRST), ph_idx_r[6:0]);

  // internal memory claims the whole range; external decode must stand aside
  assign dmem_select = ph_valid_r && ph_is_mem;

  // memory reads take one wait state so the ram output register is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wait_r <= 1'b0;
    end else begin
      ph_wait_r <= ph_valid_r && !ph_write_r && ph_is_mem && !ph_wait_r;
    end
  end

  assign hreadyout = !(ph_valid_r && !ph_write_r && ph_is_mem && !ph_wait_r);
  assign mem_we = ph_valid_r && ph_write_r && ph_is_mem;

  // ************************************************************
  // control registers
  // ************************************************************
  lcddc_cfg_type cfg_r;
  logic hlp_r;
  logic rsv_a_r;
  logic rsv_b_r;
  logic rsv_c_r;
  logic wr_mode;
  logic wr_disp;

  assign wr_mode = ph_valid_r && ph_write_r && ph_is_mode;
  assign wr_disp = ph_valid_r && ph_write_r && ph_is_disp;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r.duty_select <= RST_DUTY;
      cfg_r.font_select <= RST_FONT;
      hlp_r <= RST_RSV;
      rsv_a_r <= RST_RSV;
      rsv_b_r <= RST_RSV;
      rsv_c_r <= RST_RSV;
    end else if (wr_mode) begin
      cfg_r.duty_select <= hwdata[MODE_DUTY_BIT];
      cfg_r.font_select <= hwdata[MODE_FONT_BIT];
      hlp_r <= hwdata[MODE_HLP_BIT];
      rsv_a_r <= hwdata[MODE_RSVA_BIT];
      rsv_b_r <= hwdata[MODE_RSVB_BIT];
      rsv_c_r <= hwdata[MODE_RSVC_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r.area_select <= RST_AREA;
      cfg_r.display_state <= lcddc_state_type'(RST_STATE);
      cfg_r.contrast_code <= RST_CONTRAST;
    end else begin
      if (wr_disp) begin
        cfg_r.area_select <= hwdata[DISP_AREA_BIT];
        cfg_r.display_state <= lcddc_state_type'(hwdata[DISP_STATE_LSB +: 2]);
        cfg_r.contrast_code <= hwdata[DISP_CON_LSB +: 4];
      end
      // hardware clear outranks a software write in the same cycle
      if (sleep_instruction) begin
        cfg_r.display_state <= DS_DRIVE_OFF;
      end
    end
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    if (ph_valid_r && !ph_write_r) begin
      if (ph_is_mem) begin
        hrdata = {24'h000000, mem_rdata};
      end else if (ph_is_mode) begin
        hrdata = {24'h000000, hlp_r, 2'h0, rsv_a_r, rsv_b_r, cfg_r.font_select,
                  cfg_r.duty_select, rsv_c_r};
      end else if (ph_is_disp) begin
        hrdata = {24'h000000, 1'b0, cfg_r.area_select, cfg_r.display_state,
                  cfg_r.contrast_code};
      end
    end
  end

  // ************************************************************
  // common scan
  // ************************************************************
  typedef enum logic [1:0] {
    SC_IDLE = 2'h0,
    SC_FETCH = 2'h1,
    SC_DRAIN = 2'h3
  } lcddc_scan_type;

  lcddc_scan_type sc_r;
  logic [$clog2(COM_TICK)-1:0] div_r;
  logic tick;
  logic [3:0] fetch_com_r;
  logic [3:0] show_com_r;
  logic [6:0] seg_idx_r;
  logic [6:0] cap_idx_r;
  logic cap_vld_r;
  logic [2:0] cap_bit_r;
  logic [5:0] loc;
  logic [SEG_COUNT-1:0] buf_r;
  logic [SEG_COUNT-1:0] line_r;
  logic [DMEM_AW-1:0] scan_addr;
  logic [3:0] com_last;
  logic [7:0] scan_rdata;

  assign tick = div_r == '0;
  assign com_last = cfg_r.duty_select ? 4'hF : 4'h7;
  assign loc = scan_loc(cfg_r, fetch_com_r);
  assign scan_addr = dmem_index(loc[5:3], seg_idx_r);

  // one common period per tick; long so a whole line is fetched in between
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= '0;
    end else if (tick) begin
      div_r <= ($clog2(COM_TICK))'(COM_TICK - 1);
    end else begin
      div_r <= div_r - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc_r <= SC_IDLE;
      seg_idx_r <= '0;
    end else begin
      case (sc_r)
        SC_IDLE: begin
          if (tick) begin
            sc_r <= SC_FETCH;
            seg_idx_r <= '0;
          end
        end
        SC_FETCH: begin
          if (seg_idx_r == 7'(SEG_COUNT - 1)) begin
            sc_r <= SC_DRAIN;
          end else begin
            seg_idx_r <= seg_idx_r + 1'b1;
          end
        end
        SC_DRAIN: sc_r <= SC_IDLE;
        default: sc_r <= SC_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_vld_r <= 1'b0;
      cap_idx_r <= '0;
      cap_bit_r <= '0;
    end else begin
      cap_vld_r <= sc_r == SC_FETCH;
      cap_idx_r <= seg_idx_r;
      cap_bit_r <= loc[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_r <= '0;
    end else if (cap_vld_r) begin
      buf_r[cap_idx_r] <= scan_rdata[cap_bit_r];
    end
  end

  // the line fetched in the last period is shown while the next one is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_com_r <= '0;
      show_com_r <= '0;
      line_r <= '0;
    end else if (tick) begin
      show_com_r <= fetch_com_r;
      line_r <= buf_r;
      fetch_com_r <= (fetch_com_r >= com_last) ? 4'h0 : fetch_com_r + 1'b1;
    end
  end

  lcddc_mem #(
    .DW(8),
    .DEPTH(DMEM_BYTES),
    .AW(DMEM_AW)
  ) u_mem (
    .clk(hclk),
    .rst_n(hresetn),
    .a_addr(ph_mem_idx),
    .a_we(mem_we),
    .a_wdata(hwdata[7:0]),
    .a_rdata(mem_rdata),
    .b_addr(scan_addr),
    .b_rdata(scan_rdata)
  );

  // ************************************************************
  // panel drive
  // ************************************************************
  logic [COM_COUNT-1:0] com_sel;

  always_comb begin
    com_sel = '0;
    if (show_com_r <= com_last) begin
      com_sel[show_com_r] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      common_outputs <= '0;
      segment_outputs <= '0;
      drive_level_on <= 4'h0;
    end else begin
      case (cfg_r.display_state)
        DS_ALL_ON: begin
          common_outputs <= '1;
          segment_outputs <= '1;
          drive_level_on <= 4'hF;
        end
        DS_ALL_OFF: begin
          common_outputs <= com_sel;
          segment_outputs <= '0;
          drive_level_on <= 4'hF;
        end
        DS_NORMAL: begin
          common_outputs <= com_sel;
          segment_outputs <= line_r;
          drive_level_on <= 4'hF;
        end
        default: begin
          common_outputs <= '0;
          segment_outputs <= '0;
          drive_level_on <= 4'h0;
        end
      endcase
    end
  end

  assign contrast_code = cfg_r.contrast_code;
  assign heavy_load_protect = hlp_r;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_mem_rd;
    ph_valid_r && !ph_write_r && ph_is_mem && !ph_wait_r;
  endsequence

  sequence s_wait_then_done;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_COM_HI_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(!cfg_r.duty_select) && $past(cfg_r.display_state) != DS_ALL_ON
    |-> common_outputs[15:8] == 8'h00)
    else $error("upper commons active at 1/8 duty");

  AST_DUTY_ONEHOT: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(cfg_r.display_state) == DS_NORMAL |-> $onehot0(common_outputs))
    else $error("more than one common selected while scanning");

  AST_DRIVE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(cfg_r.display_state) == DS_DRIVE_OFF
    |-> drive_level_on == 4'h0 && common_outputs == '0)
    else $error("drive levels up while drive is off");

  AST_ALL_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(cfg_r.display_state) == DS_ALL_ON
    |-> &common_outputs && &segment_outputs && drive_level_on == 4'hF)
    else $error("all-on state not static");

  AST_ALL_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(cfg_r.display_state) == DS_ALL_OFF |-> segment_outputs == '0)
    else $error("segments lit in all-off state");

  AST_SLEEP_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_instruction |=> cfg_r.display_state == DS_DRIVE_OFF ##1 drive_level_on == 4'h0)
    else $error("sleep did not force drive off");

  AST_MODE_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_mode |=> cfg_r.duty_select == $past(hwdata[1]) && cfg_r.font_select == $past(hwdata[2]))
    else $error("mode register write not stored");

  AST_DISP_RD: assert property (@(posedge hclk) disable iff (!hresetn)
    ph_valid_r && !ph_write_r && ph_is_disp
    |-> hrdata[7] == 1'b0 && hrdata[3:0] == cfg_r.contrast_code)
    else $error("display register readback wrong");

  AST_MEM_RD_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
    s_mem_rd |-> s_wait_then_done)
    else $error("memory read wait state wrong");

  AST_NO_MEM_WR: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_disp || wr_mode |-> !mem_we)
    else $error("register write reached display memory");

  AST_CONTRAST: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_disp && !sleep_instruction |=> contrast_code == $past(hwdata[3:0]))
    else $error("contrast code not applied");

endmodule

// >>> lcddc_panel.sv
// panel model: latches the row shown on each scanned common
// assumes registered common and segment flags on hclk, drive flags all up to light
`timescale 1ns/10ps
module lcddc_panel
  import lcddc_pkg::*;
(
  input wire logic hclk,
  input wire logic clear,
  input wire logic [COM_COUNT-1:0] common_outputs,
  input wire logic [SEG_COUNT-1:0] segment_outputs,
  input wire logic [3:0] drive_level_on,
  output logic [SEG_COUNT-1:0] row_seen [COM_COUNT],
  output logic [COM_COUNT-1:0] com_seen,
  output logic multi_seen
);
  // ************************************************************
  // glass
  // ************************************************************
  // without drive power the glass shows nothing, so nothing is latched
  always @(posedge hclk) begin
    if (clear) begin
      com_seen <= '0;
      multi_seen <= 1'b0;
    end else if (drive_level_on == 4'hF) begin
      com_seen <= com_seen | common_outputs;
      if ($countones(common_outputs) > 1) begin
        multi_seen <= 1'b1;
      end
      for (int c = 0; c < COM_COUNT; c++) begin
        if (common_outputs[c]) begin
          row_seen[c] <= segment_outputs;
        end
      end
    end
  end
endmodule

// >>> testbench.sv
// self-checking bench: registers, display memory and panel scan
// assumes one AHB-Lite master (this bench) and the panel model on the scan outputs
`timescale 1ns/10ps
module testbench
  import lcddc_pkg::*;
;
  localparam int TICK = 100;
  localparam int FRAME = TICK * COM_COUNT;
  logic hclk, hresetn, hsel, hwrite, sleep_instruction, clear, dsel;
  logic [31:0] haddr, hwdata, hrdata, rd_val, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, dmem_select, heavy_load_protect, multi_seen;
  logic [COM_COUNT-1:0] common_outputs, com_seen;
  logic [SEG_COUNT-1:0] segment_outputs;
  logic [SEG_COUNT-1:0] row_seen [COM_COUNT];
  logic [3:0] drive_level_on, contrast_code;
  logic [7:0] img [6][SEG_COUNT];
  logic [31:0] exp_q [$];
  string name_q [$];
  int errors, total_checks, cycles;
  event rd_evt;

  lcddc_top #(.COM_TICK(TICK)) u_lcddc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sleep_instruction(sleep_instruction), .dmem_select(dmem_select),
    .common_outputs(common_outputs), .segment_outputs(segment_outputs),
    .drive_level_on(drive_level_on), .contrast_code(contrast_code),
    .heavy_load_protect(heavy_load_protect));
  lcddc_panel u_lcddc_panel (.hclk(hclk), .clear(clear), .common_outputs(common_outputs),
    .segment_outputs(segment_outputs), .drive_level_on(drive_level_on),
    .row_seen(row_seen), .com_seen(com_seen), .multi_seen(multi_seen));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input string nm, input logic [79:0] e, input logic [79:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // entered just after a rising edge; waits as long as the slave stalls
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    dsel = dmem_select;
    rd_val = hrdata;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    bus(1'b0, a, 32'h0);
    -> rd_evt;
  endtask

  function automatic logic [31:0] ba(input logic [15:0] idx);
    return {14'h0, idx, 2'h0};
  endfunction

  function automatic logic [31:0] ma(input int p, input int o);
    return ba({DMEM_PAGE_FIRST + p[7:0], o[7:0]});
  endfunction

  function automatic logic [79:0] exp_row(input int c, input logic font, input logic area);
    logic [79:0] r;
    int pg;
    int b;
    pg = (area ? 2 : 0) + (font ? c / 5 : c / 8);
    b = font ? c % 5 : c % 8;
    for (int s = 0; s < SEG_COUNT; s++) begin
      r[s] = img[pg][s][b];
    end
    return r;
  endfunction

  task automatic mem_verify();
    for (int p = 0; p < 6; p++) begin
      for (int s = 0; s < SEG_COUNT; s++) begin
        rd(ma(p, s), {24'h0, img[p][s]}, "display memory");
      end
    end
  endtask

  // rows shown were fetched one period earlier, so let two frames pass first
  task automatic settle();
    repeat (2 * FRAME) @(posedge hclk);
    clear <= 1'b1;
    @(posedge hclk);
    clear <= 1'b0;
    repeat (FRAME + TICK) @(posedge hclk);
  endtask

  // ************************************************************
  // clock, monitor, timeout
  // ************************************************************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial forever begin
    @(rd_evt);
    check(name_q.pop_front(), {48'h0, exp_q.pop_front()}, {48'h0, rd_val});
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("FAIL run_length expected 90000 seen 90000");
      wrap_up();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sleep_instruction = 1'b0;
    clear = 1'b0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    void'($urandom(32'h8001));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("drive_level_on reset", 4'h0, drive_level_on);
    check("hresp", 1'b0, hresp);
    rd(ba(REG_MODE_IDX), 32'h02, "mode reset");
    rd(ba(REG_DISP_IDX), 32'h0, "display reset");
    check("dmem_select register", 1'b0, dsel);
    for (int i = 0; i < 16; i++) begin
      v = $urandom();
      bus(1'b1, ba(REG_MODE_IDX), v);
      rd(ba(REG_MODE_IDX), {24'h0, v[7:0] & 8'h9F}, "mode readback");
      check("heavy_load_protect", v[7], heavy_load_protect);
      v[3:0] = i[3:0];
      bus(1'b1, ba(REG_DISP_IDX), v);
      rd(ba(REG_DISP_IDX), {24'h0, v[7:0] & 8'h7F}, "display readback");
      check("contrast_code", i[3:0], contrast_code);
    end
    bus(1'b1, 32'h4000_0000 | ba(REG_DISP_IDX), 32'hFF);
    rd(32'h4000_0000 | ba(REG_DISP_IDX), 32'h0, "unmapped read");
    rd(ba(REG_DISP_IDX), {24'h0, v[7:0] & 8'h7F}, "display after stray");
    for (int p = 0; p < 6; p++) begin
      for (int s = 0; s < SEG_COUNT; s++) begin
        v = $urandom();
        img[p][s] = v[7:0];
        bus(1'b1, ma(p, s), v & 32'hFF);
        check("dmem_select", 1'b1, dsel);
      end
    end
    mem_verify();
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, ba(REG_MODE_IDX), {29'h0, k[1], k[2], 1'b0});
      bus(1'b1, ba(REG_DISP_IDX), {25'h0, k[0], 2'h1, 4'h0});
      settle();
      check("drive normal", 4'hF, drive_level_on);
      check("com_seen", k[2] ? 16'hFFFF : 16'h00FF, com_seen);
      check("multi_seen", 1'b0, multi_seen);
      for (int c = 0; c < (k[2] ? 16 : 8); c++) begin
        check("row", exp_row(c, k[1], k[0]), row_seen[c]);
      end
    end
    bus(1'b1, ba(REG_MODE_IDX), 32'h02);
    bus(1'b1, ba(REG_DISP_IDX), 32'h20);
    settle();
    check("all-off commons", 16'hFFFF, com_seen);
    for (int c = 0; c < 16; c++) begin
      check("all-off row", 80'h0, row_seen[c]);
    end
    bus(1'b1, ba(REG_DISP_IDX), 32'h30);
    repeat (3) @(posedge hclk);
    check("all-on commons", 16'hFFFF, common_outputs);
    check("all-on segments", {80{1'b1}}, segment_outputs);
    bus(1'b1, ba(REG_DISP_IDX), 32'h00);
    repeat (3) @(posedge hclk);
    check("drive off levels", 4'h0, drive_level_on);
    check("drive off commons", 16'h0, common_outputs);
    mem_verify();
    bus(1'b1, ba(REG_DISP_IDX), 32'h5A);
    sleep_instruction <= 1'b1;
    @(posedge hclk);
    sleep_instruction <= 1'b0;
    repeat (2) @(posedge hclk);
    check("drive after sleep", 4'h0, drive_level_on);
    rd(ba(REG_DISP_IDX), 32'h4A, "display after sleep");
    repeat (2) @(posedge hclk);
    wrap_up();
  end
endmodule
